/* File: core/qss_pkg.sv */
// constants and types for the quad supply reset supervisor
package qss_pkg;

  // ----------------------------------------------------------------
  // sequencer states and threshold selects
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    QSS_ST_OFF  = 2'b00,
    QSS_ST_PROG = 2'b01,
    QSS_ST_RUN  = 2'b10
  } qss_state_type;

  typedef enum logic [2:0] {
    QSS_TH_5V0  = 3'b000,
    QSS_TH_3V3  = 3'b001,
    QSS_TH_3V0  = 3'b010,
    QSS_TH_2V5  = 3'b011,
    QSS_TH_1V8  = 3'b100,
    QSS_TH_1V5  = 3'b101,
    QSS_TH_ADJP = 3'b110,
    QSS_TH_ADJN = 3'b111
  } qss_thr_type;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int QSS_CLK_NS         = 20;
  localparam int QSS_PROG_US        = 150;
  localparam int QSS_PROG_CYC       = QSS_PROG_US * 1000 / QSS_CLK_NS;
  localparam int QSS_MIN_DLY_US     = 50;
  localparam int QSS_MIN_DLY_CYC    =
    (QSS_MIN_DLY_US * 1000 + QSS_CLK_NS - 1) / QSS_CLK_NS;
  // 4.6 ms per nF is 4600 ns per pF of timing capacitance
  localparam int QSS_DLY_NS_PER_PF  = 4600;
  localparam int QSS_DLY_CYC_PER_PF = QSS_DLY_NS_PER_PF / QSS_CLK_NS;
  localparam int QSS_CAP_PF         = 0;

  function automatic int qss_delay_cyc(input int cap_pf);
    int c;
    c = cap_pf * QSS_DLY_CYC_PER_PF;
    return (c < QSS_MIN_DLY_CYC) ? QSS_MIN_DLY_CYC : c;
  endfunction

  // ----------------------------------------------------------------
  // mode table: {input one, two, three, four}
  // ----------------------------------------------------------------
  localparam int QSS_MODES = 16;
  localparam logic [11:0] QSS_MODE_TAB [QSS_MODES] = '{
    {QSS_TH_5V0, QSS_TH_3V3, QSS_TH_ADJP, QSS_TH_ADJP},
    {QSS_TH_5V0, QSS_TH_3V3, QSS_TH_ADJP, QSS_TH_ADJN},
    {QSS_TH_3V3, QSS_TH_2V5, QSS_TH_ADJP, QSS_TH_ADJP},
    {QSS_TH_3V3, QSS_TH_2V5, QSS_TH_ADJP, QSS_TH_ADJN},
    {QSS_TH_3V3, QSS_TH_2V5, QSS_TH_1V5,  QSS_TH_ADJP},
    {QSS_TH_5V0, QSS_TH_3V3, QSS_TH_2V5,  QSS_TH_ADJP},
    {QSS_TH_5V0, QSS_TH_3V3, QSS_TH_2V5,  QSS_TH_1V8},
    {QSS_TH_5V0, QSS_TH_3V3, QSS_TH_2V5,  QSS_TH_1V5},
    {QSS_TH_5V0, QSS_TH_3V0, QSS_TH_2V5,  QSS_TH_ADJP},
    {QSS_TH_5V0, QSS_TH_3V0, QSS_TH_ADJP, QSS_TH_ADJP},
    {QSS_TH_3V3, QSS_TH_2V5, QSS_TH_1V8,  QSS_TH_1V5},
    {QSS_TH_3V3, QSS_TH_2V5, QSS_TH_1V8,  QSS_TH_ADJP},
    {QSS_TH_3V3, QSS_TH_2V5, QSS_TH_1V8,  QSS_TH_ADJN},
    {QSS_TH_5V0, QSS_TH_3V3, QSS_TH_1V8,  QSS_TH_ADJN},
    {QSS_TH_5V0, QSS_TH_3V3, QSS_TH_1V8,  QSS_TH_ADJP},
    {QSS_TH_5V0, QSS_TH_3V0, QSS_TH_1V8,  QSS_TH_ADJP}
  };

  // ----------------------------------------------------------------
  // register map and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] QSS_ADDR_CTRL   = 8'h00;
  localparam logic [7:0] QSS_ADDR_DELAY  = 8'h04;
  localparam logic [7:0] QSS_ADDR_STATUS = 8'h08;
  localparam int QSS_CTRL_SOFT_BIT = 0;
  localparam int QSS_ST_RSTN_BIT   = 0;
  localparam int QSS_ST_STATE_LSB  = 1;
  localparam int QSS_ST_CMP_BIT    = 3;
  localparam int QSS_ST_MODE_LSB   = 4;
  localparam int QSS_ST_UV_LSB     = 8;
  localparam int QSS_ST_PB_BIT     = 12;
  localparam logic [1:0] QSS_RESP_OKAY   = 2'h0;
  localparam logic [1:0] QSS_RESP_DECERR = 2'h3;

  // synchroniser lanes: 0..3 flags, then button, program ok, ref ok
  localparam int QSS_SYNC_W  = 7;
  localparam int QSS_SY_PB   = 4;
  localparam int QSS_SY_PROG = 5;
  localparam int QSS_SY_REF  = 6;

endpackage

/* File: core/qss_sync_if.sv */
// raw and synchronised input lanes between top and synchroniser
`timescale 1ns/1ns
`default_nettype none
interface qss_sync_if #(parameter int W = 1);
  logic [W-1:0] raw;
  logic [W-1:0] sync;
  modport src (output raw, input sync);
  modport syn (input raw, output sync);
endinterface // qss_sync_if
`default_nettype wire

/* File: core/qss_sync.sv */
// two-stage synchroniser for the supervisor's asynchronous inputs
`timescale 1ns/1ns
`default_nettype none
module qss_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic clk_en,
  // lanes
  qss_sync_if.syn   sif
);
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_lane
      logic meta_r;
      logic sync_r;
      // first stage feeds only the second
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          meta_r <= 1'h0;
          sync_r <= 1'h0;
        end else if (clk_en) begin
          meta_r <= sif.raw[i];
          sync_r <= meta_r;
        end
      end
      assign sif.sync[i] = sync_r;
    end
  endgenerate
endmodule // qss_sync
`default_nettype wire

/* File: core/qss_top.sv */
// quad supply reset supervisor: sequencer, delay timer, AXI4-Lite regs
// Functional notes
// - any undervoltage flag forces reset low
// - all good starts timer, release after delay
// - delay scales 4.6 ms per nF
// - no capacitor still gives 50 us minimum
// - pushbutton low forces reset low
// - pushbutton release: reset after delay if good
// - pushbutton debounced by same delay timer
// - reset low as soon as supply reaches 1V
// - reset held until programming completes
// - 150 us programming window latches mode
// - comparators enabled right after programming
// - sixteen modes select threshold combinations
// - input one uses 5V or 3.3V
// - input two uses 3.3V, 3V or 2.5V
// - input three preset or positive adjustable
// - input four preset or either adjustable
// - reference lost: reprogram above 2.4V
//
// The AXI4-Lite slave port and the register addresses were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module qss_top
  import qss_pkg::*;
#(
  parameter int CAP_PF   = QSS_CAP_PF,
  parameter int PROG_CYC = QSS_PROG_CYC,
  parameter int DLY_CYC  = qss_delay_cyc(CAP_PF),
  parameter int AW       = 8
) (
  // clock, reset (reset models the 1V supply point)
  input  wire logic          clk,
  input  wire logic          rstn,
  input  wire logic          clk_en,
  // supply monitor side
  input  wire logic [3:0]    uv_flag,
  input  wire logic          pushbutton_reset_n,
  input  wire logic [3:0]    mode_select_level,
  input  wire logic          supply_prog_ok,
  input  wire logic          ref_valid,
  // comparator control
  output logic               comparator_enable,
  output qss_thr_type        thr_supply_input_one,
  output qss_thr_type        thr_supply_input_two,
  output qss_thr_type        thr_supply_input_three,
  output qss_thr_type        thr_supply_input_four,
  // system reset
  output logic               sys_reset_n,
  // axi4-lite write
  input  wire logic [AW-1:0] awaddr,
  input  wire logic          awvalid,
  output logic               awready,
  input  wire logic [31:0]   wdata,
  input  wire logic [3:0]    wstrb,
  input  wire logic          wvalid,
  output logic               wready,
  output logic [1:0]         bresp,
  output logic               bvalid,
  input  wire logic          bready,
  // axi4-lite read
  input  wire logic [AW-1:0] araddr,
  input  wire logic          arvalid,
  output logic               arready,
  output logic [31:0]        rdata,
  output logic [1:0]         rresp,
  output logic               rvalid,
  input  wire logic          rready
);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  qss_sync_if #(.W(QSS_SYNC_W)) sif ();

  assign sif.raw = {ref_valid, supply_prog_ok, pushbutton_reset_n,
                    uv_flag};

  qss_sync #(.W(QSS_SYNC_W)) u_sync (
    .clk    (clk),
    .rstn   (rstn),
    .clk_en (clk_en),
    .sif    (sif)
  );

  logic [3:0] uv_s;
  logic       pb_s;
  logic       prog_s;
  logic       ref_s;

  assign uv_s   = sif.sync[3:0];
  assign pb_s   = sif.sync[QSS_SY_PB];
  assign prog_s = sif.sync[QSS_SY_PROG];
  assign ref_s  = sif.sync[QSS_SY_REF];

  // ----------------------------------------------------------------
  // power-up sequencer
  // ----------------------------------------------------------------
  qss_state_type state_r;
  qss_state_type state_nxt;
  logic [31:0]   prog_cnt_r;
  logic [3:0]    mode_r;
  logic          prog_end_w;

  assign prog_end_w = (prog_cnt_r == 32'(PROG_CYC - 1));

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      QSS_ST_OFF: begin
        if (prog_s) state_nxt = QSS_ST_PROG;
      end
      QSS_ST_PROG: begin
        if (!prog_s) state_nxt = QSS_ST_OFF;
        else if (prog_end_w) state_nxt = QSS_ST_RUN;
      end
      QSS_ST_RUN: begin
        // lost reference forces a fresh programming pass
        if (!ref_s) state_nxt = QSS_ST_OFF;
      end
      default: state_nxt = QSS_ST_OFF;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) state_r <= QSS_ST_OFF;
    else if (clk_en) state_r <= state_nxt;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) prog_cnt_r <= 32'h0;
    else if (clk_en) begin
      if (state_r != QSS_ST_PROG) prog_cnt_r <= 32'h0;
      else if (!prog_end_w) prog_cnt_r <= prog_cnt_r + 32'h1;
    end
  end

  // mode only changes on the programming exit edge
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) mode_r <= 4'h0;
    else if (clk_en && state_r == QSS_ST_PROG &&
             state_nxt == QSS_ST_RUN)
      mode_r <= mode_select_level;
  end

  logic [11:0] thr_w;
  assign thr_w = QSS_MODE_TAB[mode_r];
  assign thr_supply_input_one   = qss_thr_type'(thr_w[11:9]);
  assign thr_supply_input_two   = qss_thr_type'(thr_w[8:6]);
  assign thr_supply_input_three = qss_thr_type'(thr_w[5:3]);
  assign thr_supply_input_four  = qss_thr_type'(thr_w[2:0]);
  assign comparator_enable      = (state_r == QSS_ST_RUN);

  // ----------------------------------------------------------------
  // reset delay timer
  // ----------------------------------------------------------------
  logic [31:0] delay_r;
  logic        soft_r;
  logic [31:0] term_w;
  logic [31:0] cnt_r;
  logic        rel_r;
  logic        run_w;
  logic        fault_w;

  // a too-small programmed value cannot undercut the floor
  assign term_w = (delay_r < 32'(QSS_MIN_DLY_CYC)) ?
                  32'(QSS_MIN_DLY_CYC) : delay_r;
  assign run_w  = (state_r == QSS_ST_RUN) && (state_nxt == QSS_ST_RUN);
  // flags only count once comparators run; all lanes used by every mode
  assign fault_w = (run_w && (|uv_s)) || !pb_s || soft_r;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) cnt_r <= 32'h0;
    else if (clk_en) begin
      if (!run_w || fault_w) cnt_r <= 32'h0;
      else if (!rel_r) cnt_r <= cnt_r + 32'h1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) rel_r <= 1'h0;
    else if (clk_en) begin
      if (!run_w || fault_w) rel_r <= 1'h0;
      else if (cnt_r == term_w - 32'h1) rel_r <= 1'h1;
    end
  end

  assign sys_reset_n = rel_r;

  // ----------------------------------------------------------------
  // axi4-lite slave
  // ----------------------------------------------------------------
  logic          aw_got_r;
  logic [AW-1:0] aw_addr_r;
  logic          w_got_r;
  logic [31:0]   w_data_r;
  logic [3:0]    w_strb_r;
  logic          bvalid_r;
  logic [1:0]    bresp_r;
  logic          rvalid_r;
  logic [1:0]    rresp_r;
  logic [31:0]   rdata_r;
  logic          aw_hs;
  logic          w_hs;
  logic          wr_fire;
  logic [AW-1:0] wr_addr;
  logic [31:0]   wr_data;
  logic [3:0]    wr_strb;

  assign awready = clk_en && !aw_got_r && !bvalid_r;
  assign wready  = clk_en && !w_got_r && !bvalid_r;
  assign arready = clk_en && !rvalid_r;
  assign aw_hs   = awvalid && awready;
  assign w_hs    = wvalid && wready;
  assign wr_fire = (aw_got_r || aw_hs) && (w_got_r || w_hs);
  assign wr_addr = aw_got_r ? aw_addr_r : awaddr;
  assign wr_data = w_got_r ? w_data_r : wdata;
  assign wr_strb = w_got_r ? w_strb_r : wstrb;
  assign bvalid  = bvalid_r;
  assign bresp   = bresp_r;
  assign rvalid  = rvalid_r;
  assign rresp   = rresp_r;
  assign rdata   = rdata_r;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      aw_got_r  <= 1'h0;
      aw_addr_r <= '0;
      w_got_r   <= 1'h0;
      w_data_r  <= 32'h0;
      w_strb_r  <= 4'h0;
    end else if (clk_en) begin
      if (wr_fire) begin
        aw_got_r <= 1'h0;
        w_got_r  <= 1'h0;
      end else begin
        if (aw_hs) begin
          aw_got_r  <= 1'h1;
          aw_addr_r <= awaddr;
        end
        if (w_hs) begin
          w_got_r  <= 1'h1;
          w_data_r <= wdata;
          w_strb_r <= wstrb;
        end
      end
    end
  end

  logic wr_hit;
  assign wr_hit = (wr_addr == AW'(QSS_ADDR_CTRL)) ||
                  (wr_addr == AW'(QSS_ADDR_DELAY));

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bvalid_r <= 1'h0;
      bresp_r  <= QSS_RESP_OKAY;
    end else if (clk_en) begin
      if (wr_fire) begin
        bvalid_r <= 1'h1;
        bresp_r  <= wr_hit ? QSS_RESP_OKAY : QSS_RESP_DECERR;
      end else if (bready) bvalid_r <= 1'h0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) soft_r <= 1'h0;
    else if (clk_en && wr_fire && wr_addr == AW'(QSS_ADDR_CTRL) &&
             wr_strb[0])
      soft_r <= wr_data[QSS_CTRL_SOFT_BIT];
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) delay_r <= 32'(DLY_CYC);
    else if (clk_en && wr_fire && wr_addr == AW'(QSS_ADDR_DELAY)) begin
      for (int b = 0; b < 4; b++) begin
        if (wr_strb[b]) delay_r[b*8 +: 8] <= wr_data[b*8 +: 8];
      end
    end
  end

  logic [31:0] status_w;
  always_comb begin
    status_w = 32'h0;
    status_w[QSS_ST_RSTN_BIT] = rel_r;
    status_w[QSS_ST_STATE_LSB +: 2] = state_r;
    status_w[QSS_ST_CMP_BIT] = comparator_enable;
    status_w[QSS_ST_MODE_LSB +: 4] = mode_r;
    status_w[QSS_ST_UV_LSB +: 4] = uv_s;
    status_w[QSS_ST_PB_BIT] = pb_s;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rvalid_r <= 1'h0;
      rresp_r  <= QSS_RESP_OKAY;
      rdata_r  <= 32'h0;
    end else if (clk_en) begin
      if (arvalid && arready) begin
        rvalid_r <= 1'h1;
        rresp_r  <= QSS_RESP_OKAY;
        if (araddr == AW'(QSS_ADDR_CTRL))
          rdata_r <= {31'h0, soft_r};
        else if (araddr == AW'(QSS_ADDR_DELAY))
          rdata_r <= delay_r;
        else if (araddr == AW'(QSS_ADDR_STATUS))
          rdata_r <= status_w;
        else begin
          rdata_r <= 32'h0;
          rresp_r <= QSS_RESP_DECERR;
        end
      end else if (rready) rvalid_r <= 1'h0;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_in_prog;
    state_r == QSS_ST_PROG;
  endsequence

  sequence s_enter_run;
    clk_en && state_r == QSS_ST_PROG && state_nxt == QSS_ST_RUN;
  endsequence

  chk_uv_low_reset : assert property (
    clk_en && run_w && (|uv_s) |=> !sys_reset_n)
    else $error("undervoltage did not hold reset low");

  chk_pb_low_reset : assert property (
    clk_en && !pb_s |=> !sys_reset_n)
    else $error("pushbutton did not force reset low");

  chk_release_time : assert property (
    $rose(sys_reset_n) |-> $past(cnt_r) == $past(term_w) - 32'h1)
    else $error("reset released before the delay ran out");

  chk_delay_floor : assert property (
    term_w >= 32'(QSS_MIN_DLY_CYC))
    else $error("release delay below the minimum");

  chk_fault_restart : assert property (
    clk_en && fault_w |=> cnt_r == 32'h0 && !sys_reset_n)
    else $error("fault did not restart the delay");

  chk_hold_unprog : assert property (
    state_r != QSS_ST_RUN |-> !sys_reset_n)
    else $error("reset released before programming");

  chk_prog_length : assert property (
    s_in_prog ##0 s_enter_run |-> prog_cnt_r == 32'(PROG_CYC - 1)
      ##1 comparator_enable && mode_r == $past(mode_select_level))
    else $error("programming window length or mode latch wrong");

  chk_mode_held : assert property (
    run_w && $past(run_w) |-> $stable(mode_r))
    else $error("mode changed outside programming");

  chk_reprogram : assert property (
    clk_en && comparator_enable && !ref_s |=> state_r == QSS_ST_OFF
      ##0 !comparator_enable)
    else $error("lost reference did not restart programming");

  chk_thr_one : assert property (
    thr_supply_input_one inside {QSS_TH_5V0, QSS_TH_3V3})
    else $error("input one threshold out of set");

  chk_thr_two : assert property (
    thr_supply_input_two inside {QSS_TH_3V3, QSS_TH_3V0, QSS_TH_2V5})
    else $error("input two threshold out of set");

  chk_thr_three : assert property (
    thr_supply_input_three inside {QSS_TH_2V5, QSS_TH_1V8,
                                   QSS_TH_1V5, QSS_TH_ADJP})
    else $error("input three threshold out of set");

  chk_thr_four : assert property (
    thr_supply_input_four inside {QSS_TH_1V8, QSS_TH_1V5,
                                  QSS_TH_ADJP, QSS_TH_ADJN})
    else $error("input four threshold out of set");

endmodule // qss_top
`default_nettype wire

/* File: verif/qss_sys_model.sv */
// partner model: system logic that receives the supervisor reset
`timescale 1ns/1ns
`default_nettype none
module qss_sys_model (
  // clock
  input  wire logic        clk,
  // reset line from the supervisor
  input  wire logic        sys_reset_n,
  // what the system saw
  output logic [31:0]      low_len,
  output logic [31:0]      releases
);
  logic [31:0] run_r;

  // the system stays in reset while the line is low and notes how long
  initial begin
    run_r    = 32'h0;
    low_len  = 32'h0;
    releases = 32'h0;
    forever begin
      @(posedge clk);
      if (sys_reset_n === 1'b0) begin
        run_r <= run_r + 32'h1;
      end else if (run_r != 32'h0) begin
        low_len  <= run_r;
        releases <= releases + 32'h1;
        run_r    <= 32'h0;
      end
    end
  end
endmodule // qss_sys_model
`default_nettype wire

/* File: verif/tb.sv */
// self-checking testbench for the quad supply reset supervisor
`timescale 1ns/1ns
`default_nettype none
module tb;
  import qss_pkg::*;
  // minimum release delay: 50 us at 20 ns a cycle
  localparam int TERM = 50000 / 20;
  localparam logic [15:0] ROWS [16] = '{
    {4'h0, QSS_TH_5V0, QSS_TH_3V3, QSS_TH_ADJP, QSS_TH_ADJP},
    {4'h1, QSS_TH_5V0, QSS_TH_3V3, QSS_TH_ADJP, QSS_TH_ADJN},
    {4'h2, QSS_TH_3V3, QSS_TH_2V5, QSS_TH_ADJP, QSS_TH_ADJP},
    {4'h3, QSS_TH_3V3, QSS_TH_2V5, QSS_TH_ADJP, QSS_TH_ADJN},
    {4'h4, QSS_TH_3V3, QSS_TH_2V5, QSS_TH_1V5,  QSS_TH_ADJP},
    {4'h5, QSS_TH_5V0, QSS_TH_3V3, QSS_TH_2V5,  QSS_TH_ADJP},
    {4'h6, QSS_TH_5V0, QSS_TH_3V3, QSS_TH_2V5,  QSS_TH_1V8},
    {4'h7, QSS_TH_5V0, QSS_TH_3V3, QSS_TH_2V5,  QSS_TH_1V5},
    {4'h8, QSS_TH_5V0, QSS_TH_3V0, QSS_TH_2V5,  QSS_TH_ADJP},
    {4'h9, QSS_TH_5V0, QSS_TH_3V0, QSS_TH_ADJP, QSS_TH_ADJP},
    {4'hA, QSS_TH_3V3, QSS_TH_2V5, QSS_TH_1V8,  QSS_TH_1V5},
    {4'hB, QSS_TH_3V3, QSS_TH_2V5, QSS_TH_1V8,  QSS_TH_ADJP},
    {4'hC, QSS_TH_3V3, QSS_TH_2V5, QSS_TH_1V8,  QSS_TH_ADJN},
    {4'hD, QSS_TH_5V0, QSS_TH_3V3, QSS_TH_1V8,  QSS_TH_ADJN},
    {4'hE, QSS_TH_5V0, QSS_TH_3V3, QSS_TH_1V8,  QSS_TH_ADJP},
    {4'hF, QSS_TH_5V0, QSS_TH_3V0, QSS_TH_1V8,  QSS_TH_ADJP}};

  logic clk, rstn, clk_en, pb_n, prog_ok, ref_ok, cmp_en, rst_n;
  logic [3:0] uv, mode;
  qss_thr_type th1, th2, th3, th4;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, low_len, rels, rd;
  logic [3:0] wstrb;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [1:0] bresp, rresp, rsp;
  int n_errors, checks;

  qss_top #(.PROG_CYC(8)) i_qss_top (
    .clk(clk), .rstn(rstn), .clk_en(clk_en), .uv_flag(uv),
    .pushbutton_reset_n(pb_n), .mode_select_level(mode),
    .supply_prog_ok(prog_ok), .ref_valid(ref_ok),
    .comparator_enable(cmp_en), .thr_supply_input_one(th1),
    .thr_supply_input_two(th2), .thr_supply_input_three(th3),
    .thr_supply_input_four(th4), .sys_reset_n(rst_n),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready));

  qss_sys_model i_qss_sys_model (
    .clk(clk), .sys_reset_n(rst_n), .low_len(low_len),
    .releases(rels));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic results;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // the long waits are a handful of release delays; this is far beyond
  initial begin
    repeat (60000) @(posedge clk);
    n_errors++;
    results();
  end

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_lvl(input logic got, input logic exp);
    check_val({31'h0, got}, {31'h0, exp});
  endtask

  // checks happen at falling edges, where every flop has settled
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        output logic [1:0] r);
    logic aw_ok, w_ok, b_ok;
    int n;
    b_ok = 1'b0;
    n = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b_ok && n < 200) begin
      @(negedge clk);
      aw_ok = awvalid & awready;
      w_ok = wvalid & wready;
      b_ok = (bvalid === 1'b1);
      r = bresp;
      @(posedge clk);
      if (aw_ok) awvalid <= 1'b0;
      if (w_ok) wvalid <= 1'b0;
      if (b_ok) bready <= 1'b0;
      n++;
    end
    if (!b_ok) n_errors++;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    logic ar_ok, r_ok;
    int n;
    r_ok = 1'b0;
    n = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!r_ok && n < 200) begin
      @(negedge clk);
      ar_ok = arvalid & arready;
      r_ok = (rvalid === 1'b1);
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (ar_ok) arvalid <= 1'b0;
      if (r_ok) rready <= 1'b0;
      n++;
    end
    if (!r_ok) n_errors++;
  endtask

  // release must not come before term - 5 cycles, and must come within 20 cycles after that
  task automatic expect_release(input int term);
    int n;
    wait_n(term - 5);
    check_lvl(rst_n, 1'b0);
    n = 0;
    while (rst_n !== 1'b1 && n < 20) begin
      wait_n(1);
      n++;
    end
    check_lvl(rst_n, 1'b1);
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    {rstn, pb_n, prog_ok, ref_ok, uv, mode} = {1'b0, 1'b1, 1'b0, 1'b1,
                                               4'h0, 4'h6};
    {clk_en, wstrb, awaddr, araddr, wdata} = {1'b1, 4'hF, 48'h0};
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    n_errors = 0;
    checks = 0;
    repeat (16) @(posedge clk);
    check_lvl(rst_n, 1'b0);
    check_lvl(cmp_en, 1'b0);
    rstn <= 1'b1;
    wait_n(20);
    check_lvl(rst_n, 1'b0);
    @(posedge clk) prog_ok <= 1'b1;
    wait_n(5);
    check_lvl(cmp_en, 1'b0);
    wait_n(10);
    check_lvl(cmp_en, 1'b1);
    expect_release(TERM - 15);
    $display("done: power-up");

    for (int i = 0; i < 16; i++) begin
      @(posedge clk) ref_ok <= 1'b0;
      mode <= ROWS[i][15:12];
      wait_n(4);
      check_lvl(cmp_en, 1'b0);
      check_lvl(rst_n, 1'b0);
      @(posedge clk) ref_ok <= 1'b1;
      wait_n(16);
      check_lvl(cmp_en, 1'b1);
      check_val({20'h0, th1, th2, th3, th4}, {20'h0, ROWS[i][11:0]});
    end
    @(posedge clk) mode <= 4'h3;
    wait_n(10);
    check_val({20'h0, th1, th2, th3, th4}, {20'h0, ROWS[15][11:0]});
    expect_release(TERM - 30);
    $display("done: mode table");

    for (int b = 0; b < 4; b++) begin
      @(posedge clk) uv <= 4'h1 << b;
      wait_n(4);
      check_lvl(rst_n, 1'b0);
    end
    @(posedge clk) uv <= 4'h0;
    wait_n(1000);
    @(posedge clk) uv <= 4'h4;
    repeat (3) @(posedge clk);
    uv <= 4'h0;
    expect_release(TERM);
    $display("done: undervoltage");

    @(posedge clk) pb_n <= 1'b0;
    wait_n(4);
    check_lvl(rst_n, 1'b0);
    @(posedge clk) pb_n <= 1'b1;
    repeat (50) @(posedge clk);
    pb_n <= 1'b0;
    repeat (3) @(posedge clk);
    pb_n <= 1'b1;
    expect_release(TERM);
    // the system notes the low time one edge after the release
    wait_n(1);
    // low from press+3 to TERM edges after the bounce clears at press+59
    check_val(low_len, 32'(TERM) + 32'h38);
    check_val(rels, 32'h4);
    $display("done: pushbutton");

    axi_rd(QSS_ADDR_STATUS, rd, rsp);
    check_val(rd, 32'h0000_10FD);
    check_val({30'h0, rsp}, {30'h0, QSS_RESP_OKAY});
    axi_wr(8'h0C, 32'h0000_1234, rsp);
    check_val({30'h0, rsp}, {30'h0, QSS_RESP_DECERR});
    axi_rd(8'h0C, rd, rsp);
    check_val({rd[29:0], rsp}, {30'h0, QSS_RESP_DECERR});
    axi_wr(QSS_ADDR_DELAY, 32'h0000_0BB8, rsp);
    axi_rd(QSS_ADDR_DELAY, rd, rsp);
    check_val(rd, 32'h0000_0BB8);
    axi_wr(QSS_ADDR_CTRL, 32'h0000_0001, rsp);
    wait_n(4);
    check_lvl(rst_n, 1'b0);
    axi_wr(QSS_ADDR_CTRL, 32'h0000_0000, rsp);
    expect_release(3000);
    $display("done: registers");

    // a frozen block must not see a button press made while frozen
    @(posedge clk) clk_en <= 1'b0;
    pb_n <= 1'b0;
    wait_n(8);
    check_lvl(rst_n, 1'b1);
    check_lvl(awready, 1'b0);
    @(posedge clk) clk_en <= 1'b1;
    pb_n <= 1'b1;
    wait_n(4);
    check_lvl(rst_n, 1'b1);
    $display("done: clock enable");
    results();
  end
endmodule // tb
`default_nettype wire
